// file: dv/ahc_host_model.sv
// Purpose: operator panel model offering parsed requests
// Assumes: send is called just after a rising edge
// Notes: the send wait is scaled down to GAP cycles
`timescale 1ns/10ps
module ahc_host_model #(
  parameter int GAP = 2
)
(
  // Clock
  input wire logic ref_clk,
  // Request toward the checker
  output logic reqValid,
  output logic [3:0] reqStation,
  output logic [15:0] reqSymbol,
  output logic [7:0] reqSumRx,
  output logic [7:0] reqSumCalc,
  output ahc_pkg::ahc_area_t reqArea,
  output logic [11:0] reqAddr,
  output logic [7:0] reqCount,
  output ahc_pkg::ahc_rch_t reqRecipeChange,
  output logic [4:0] reqRecipeNum
);
  // ==========================================================================
  // Request driver; station, symbol, address and count invert once released
  initial
  begin
    reqValid = 1'b0;
    {reqStation, reqSymbol, reqSumRx, reqSumCalc, reqAddr, reqCount, reqRecipeNum} = '0;
    reqArea = ahc_pkg::AREA_FLAG;
    reqRecipeChange = ahc_pkg::RCH_NONE;
  end
  task automatic send(input logic [3:0] st, input logic [15:0] sym, input logic [7:0] sr,
    input logic [7:0] sc, input ahc_pkg::ahc_area_t ar, input logic [11:0] ad,
    input logic [7:0] cn, input ahc_pkg::ahc_rch_t rc, input logic [4:0] rn);
    if (st < 4'h1 || st > 4'h8) return;
    repeat (GAP) @(posedge ref_clk);
    #1;
    reqValid = 1'b1;
    {reqStation, reqSymbol, reqSumRx, reqSumCalc, reqAddr, reqCount, reqRecipeNum} =
      {st, sym, sr, sc, ad, cn, rn};
    reqArea = ar;
    reqRecipeChange = rc;
    @(posedge ref_clk) #1;
    reqValid = 1'b0;
    {reqStation, reqSymbol, reqAddr, reqCount} = ~{reqStation, reqSymbol, reqAddr, reqCount};
  endtask
endmodule

// file: dv/ahc_monitor.sv
// Purpose: concurrent checks on the request checker verdict
// Assumes: one parsed request per reqValid pulse
// Notes: codes follow the fixed check priority
`timescale 1ns/10ps
module ahc_monitor #(
  parameter int RECIPES = 32
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Request
  input wire logic reqValid,
  input wire logic [15:0] reqSymbol,
  input wire logic [7:0] reqSumRx,
  input wire logic [7:0] reqSumCalc,
  input wire ahc_pkg::ahc_area_t reqArea,
  input wire logic [11:0] reqAddr,
  input wire logic [7:0] reqCount,
  // Verdict
  input wire logic rspValid,
  input wire logic rspOk,
  input wire logic [7:0] rspCode,
  input wire logic execStb
);
  // ==========================================================================
  // Properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  logic sumOk;
  // Checksum agreement gates every later check
  assign sumOk = reqSumRx == reqSumCalc;
  sequence s_req(sym, area, addr, cnt);
    reqValid && sumOk && reqSymbol == sym && reqArea == area && reqAddr == addr
      && reqCount == cnt;
  endsequence
  property p_cause;
    rspValid |-> $past(reqValid);
  endproperty
  a_cause: assert property (p_cause) else $error("response without request");
  property p_exec;
    execStb |-> rspValid && rspOk && rspCode == 8'h00;
  endproperty
  a_exec: assert property (p_exec) else $error("execute with error code");
  property p_sum;
    reqValid && !sumOk ##1 rspValid |-> rspCode == 8'h01 && !execStb;
  endproperty
  a_sum: assert property (p_sum) else $error("bad checksum not flagged");
  property p_cmd;
    reqValid && sumOk && !(reqSymbol inside {16'h4252, 16'h5752, 16'h4257, 16'h5757,
      16'h4a52, 16'h5152, 16'h4a57, 16'h5157, 16'h5454}) ##1 rspValid |-> rspCode == 8'h02;
  endproperty
  a_cmd: assert property (p_cmd) else $error("unknown symbol not flagged");
  property p_range;
    s_req(16'h5752, ahc_pkg::AREA_CURRENT, 12'h0a2, 8'h02) ##1 rspValid |-> rspCode == 8'h03;
  endproperty
  a_range: assert property (p_range) else $error("range overrun not flagged");
  property p_flag;
    s_req(16'h5157, ahc_pkg::AREA_FLAG, 12'h000, 8'h02) ##1 rspValid |-> rspCode == 8'h04;
  endproperty
  a_flag: assert property (p_flag) else $error("word write to flags not flagged");
  property p_odd_cnt;
    s_req(16'h5757, ahc_pkg::AREA_CURRENT, 12'h000, 8'h03) ##1 rspValid |-> rspCode == 8'h05;
  endproperty
  a_odd_cnt: assert property (p_odd_cnt) else $error("odd count not flagged");
  property p_odd_adr;
    s_req(16'h5752, ahc_pkg::AREA_CURRENT, 12'h001, 8'h02) ##1 rspValid |-> rspCode == 8'h06;
  endproperty
  a_odd_adr: assert property (p_odd_adr) else $error("odd address not flagged");
endmodule
bind analyzer_host_command_checker ahc_monitor #(.RECIPES(RECIPES)) u_mon (.ref_clk(ref_clk),
  .rstn(rstn), .reqValid(reqValid), .reqSymbol(reqSymbol), .reqSumRx(reqSumRx),
  .reqSumCalc(reqSumCalc), .reqArea(reqArea), .reqAddr(reqAddr), .reqCount(reqCount),
  .rspValid(rspValid), .rspOk(rspOk), .rspCode(rspCode), .execStb(execStb));

// file: dv/tb_analyzer_host_command_checker.sv
// Purpose: self-checking bench for the host request checker
// Assumes: own station strapped to 5
// Notes: a reference function mirrors the check priority
`timescale 1ns/10ps
module tb_analyzer_host_command_checker;
  // ==========================================================================
  // Signals and model state
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [3:0] stationSel = 4'h5;
  logic recipeWrite = 1'b0;
  logic [4:0] recipeWriteNum = 5'h00;
  logic [31:0] measuring = 32'h0000_0005;
  logic reqValid, rspValid, rspOk, execStb, stationBad;
  logic [3:0] reqStation;
  logic [15:0] reqSymbol;
  logic [7:0] reqSumRx, reqSumCalc, reqCount, rspCode;
  logic [11:0] reqAddr;
  logic [4:0] reqRecipeNum;
  ahc_pkg::ahc_area_t reqArea;
  ahc_pkg::ahc_rch_t reqRecipeChange;
  int bad_count = 0;
  int total_checks = 0;
  int own = 5;
  bit regd[32];
  logic [31:0] seed = 32'd23;
  logic [31:0] r;
  logic [15:0] syms[10] = '{16'h4252, 16'h5752, 16'h4257, 16'h5757, 16'h4a52, 16'h5152,
    16'h4a57, 16'h5157, 16'h5454, 16'h4141};
  int maxa[7] = '{'h04f, 'h0a0, 'h062, 'h832, 'h852, 'h896, 'h92a};
  always #5 ref_clk = ~ref_clk;
  analyzer_host_command_checker uut (.ref_clk(ref_clk), .rstn(rstn), .stationSel(stationSel),
    .reqValid(reqValid), .reqStation(reqStation), .reqSymbol(reqSymbol), .reqSumRx(reqSumRx),
    .reqSumCalc(reqSumCalc), .reqArea(reqArea), .reqAddr(reqAddr), .reqCount(reqCount),
    .reqRecipeChange(reqRecipeChange), .reqRecipeNum(reqRecipeNum), .recipeWrite(recipeWrite),
    .recipeWriteNum(recipeWriteNum), .measuring(measuring), .rspValid(rspValid),
    .rspOk(rspOk), .rspCode(rspCode), .execStb(execStb), .stationBad(stationBad));
  ahc_host_model host (.ref_clk(ref_clk), .reqValid(reqValid), .reqStation(reqStation),
    .reqSymbol(reqSymbol), .reqSumRx(reqSumRx), .reqSumCalc(reqSumCalc), .reqArea(reqArea),
    .reqAddr(reqAddr), .reqCount(reqCount), .reqRecipeChange(reqRecipeChange),
    .reqRecipeNum(reqRecipeNum));
  // ==========================================================================
  // Helpers
  task automatic chk(input string n, input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, exp, seen);
    end
  endtask
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Reference verdict, first failing check wins
  function automatic logic [7:0] expc(input int k0, bs, ar, ad, cn, rc, rn);
    int k;
    int ec;
    k = (k0 > 8) ? 9 : k0;
    ec = (cn == 0) ? 1 : cn;
    if (bs != 0) return 8'h01;
    if (k == 9) return 8'h02;
    if (k != 8 && ad + ec - 1 > maxa[ar]) return 8'h03;
    if (k inside {3, 7} && ar == 0) return 8'h04;
    if (k inside {1, 3, 5, 7} && ar != 0 && cn % 2) return 8'h05; // Zero count is even
    if (k != 8 && ar != 0 && ad % 2) return 8'h06;
    if (k inside {2, 3, 6, 7} && rc != 0 && !regd[rn]) return 8'(6 + rc);
    if (k inside {2, 3, 6, 7} && rc > 1 && !measuring[rn]) return 8'(8 + rc);
    return 8'h00;
  endfunction
  // One request through the host, verdict compared one cycle later
  task automatic req(input int st, k, bs, ar, ad, cn, rc, rn);
    logic [7:0] e;
    e = expc(k, bs, ar, ad, cn, rc, rn);
    host.send(4'(st), syms[k], 8'h3c, 8'(8'h3c ^ bs), ahc_pkg::ahc_area_t'(ar), 12'(ad),
      8'(cn), ahc_pkg::ahc_rch_t'(rc), 5'(rn));
    chk("rspValid", rspValid, 8'(st == own));
    if (st == own)
    begin
      chk("rspCode", rspCode, e);
      chk("rspOk", rspOk, 8'(e == 0));
      chk("execStb", execStb, 8'(e == 0));
    end
  endtask
  task automatic regw(input int n);
    @(posedge ref_clk) #1;
    recipeWrite = 1'b1;
    recipeWriteNum = 5'(n);
    @(posedge ref_clk) #1;
    recipeWrite = 1'b0;
    regd[n] = 1'b1;
  endtask
  task automatic hold_reset();
    rstn = 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    rstn = 1'b1;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ==========================================================================
  // Main sequence: directed corners, recipe cases, then random traffic
  initial
  begin
    hold_reset();
    chk("stationBad", stationBad, 8'h00);
    for (int i = 0; i < 10; i++) req(5, i, 0, 1, 0, 2, 0, 0);
    req(5, 1, 0, 1, 'h0a2, 2, 0, 0);
    req(5, 7, 0, 0, 0, 2, 0, 0);
    req(5, 3, 0, 1, 0, 3, 0, 0);
    req(5, 1, 0, 1, 1, 2, 0, 0);
    req(5, 0, 1, 0, 0, 1, 0, 0);
    req(3, 0, 0, 0, 0, 1, 0, 0);
    for (int c = 1; c < 4; c++) req(5, 3, 0, 1, 0, 2, c, 1);
    regw(1);
    regw(2);
    for (int c = 1; c < 4; c++) req(5, 3, 0, 1, 0, 2, c, 1);
    req(5, 6, 0, 1, 0, 2, 2, 2);
    repeat (80)
    begin
      r = xs();
      req((r[31:29] == 3'h0) ? 2 : 5, r % 10, r[28:26] == 3'h0, r[25:23] % 7, r[11:4],
        r[14:12], r[17:16], r[19:18]);
    end
    // Strap outside 1..10 falls back to station 1, table cleared
    stationSel = 4'hb;
    hold_reset();
    own = 1;
    regd = '{default: 1'b0};
    chk("stationBad", stationBad, 8'h01);
    req(1, 3, 0, 1, 0, 2, 1, 1);
    summarize();
  end
  // Watchdog
  initial
  begin
    #100000;
    bad_count++;
    summarize();
  end
endmodule

// file: hdl/ahc_cmd_decode.sv
// Purpose: maps a received two-letter symbol to a command class
// Assumes: symbol is stable while the request is offered
// Notes: purely combinational
`timescale 1ns/10ps
module ahc_cmd_decode
(
  // Symbol in
  input wire logic [15:0] symbol,
  // Decoded class
  output ahc_pkg::ahc_cmd_t cmd,
  output logic isWordWrite,
  output logic isWordOp,
  output logic isWrite
);

  // ==========================================================================
  // Symbol lookup
  always_comb
  begin
    case (symbol)
      ahc_pkg::SYM_BIT_READ: cmd = ahc_pkg::CMD_BIT_READ;
      ahc_pkg::SYM_WORD_READ: cmd = ahc_pkg::CMD_WORD_READ;
      ahc_pkg::SYM_BIT_WRITE: cmd = ahc_pkg::CMD_BIT_WRITE;
      ahc_pkg::SYM_WORD_WRITE: cmd = ahc_pkg::CMD_WORD_WRITE;
      ahc_pkg::SYM_EXT_READ_A: cmd = ahc_pkg::CMD_EXT_READ_A;
      ahc_pkg::SYM_EXT_READ_B: cmd = ahc_pkg::CMD_EXT_READ_B;
      ahc_pkg::SYM_EXT_WRITE_A: cmd = ahc_pkg::CMD_EXT_WRITE_A;
      ahc_pkg::SYM_EXT_WRITE_B: cmd = ahc_pkg::CMD_EXT_WRITE_B;
      ahc_pkg::SYM_LINK_TEST: cmd = ahc_pkg::CMD_LINK_TEST;
      default: cmd = ahc_pkg::CMD_UNKNOWN;
    endcase
  end

  // Word-based classes; extended B variants move words
  assign isWordWrite = (cmd == ahc_pkg::CMD_WORD_WRITE) || (cmd == ahc_pkg::CMD_EXT_WRITE_B);
  assign isWordOp = isWordWrite || (cmd == ahc_pkg::CMD_WORD_READ)
                    || (cmd == ahc_pkg::CMD_EXT_READ_B);
  assign isWrite = (cmd == ahc_pkg::CMD_BIT_WRITE) || (cmd == ahc_pkg::CMD_WORD_WRITE)
                   || (cmd == ahc_pkg::CMD_EXT_WRITE_A) || (cmd == ahc_pkg::CMD_EXT_WRITE_B);

endmodule

// file: hdl/ahc_pkg.sv
// Purpose: shared constants and types for the host request checker
// Assumes: requests arrive already parsed into fields by a framing front end
// Notes: error codes are two hex digits carried as one byte
package ahc_pkg;

  // ==========================================================================
  // Command symbols
  typedef enum logic [3:0] {
    CMD_BIT_READ,
    CMD_WORD_READ,
    CMD_BIT_WRITE,
    CMD_WORD_WRITE,
    CMD_EXT_READ_A,
    CMD_EXT_READ_B,
    CMD_EXT_WRITE_A,
    CMD_EXT_WRITE_B,
    CMD_LINK_TEST,
    CMD_UNKNOWN
  } ahc_cmd_t;

  // Two-letter ASCII symbols as received on the link
  localparam logic [15:0] SYM_BIT_READ = 16'h4252;
  localparam logic [15:0] SYM_WORD_READ = 16'h5752;
  localparam logic [15:0] SYM_BIT_WRITE = 16'h4257;
  localparam logic [15:0] SYM_WORD_WRITE = 16'h5757;
  localparam logic [15:0] SYM_EXT_READ_A = 16'h4a52;
  localparam logic [15:0] SYM_EXT_READ_B = 16'h5152;
  localparam logic [15:0] SYM_EXT_WRITE_A = 16'h4a57;
  localparam logic [15:0] SYM_EXT_WRITE_B = 16'h5157;
  localparam logic [15:0] SYM_LINK_TEST = 16'h5454;

  // ==========================================================================
  // Device areas
  typedef enum logic [2:0] {
    AREA_FLAG,
    AREA_CURRENT,
    AREA_COMMON,
    AREA_RECIPE,
    AREA_EQUIP,
    AREA_FILTER,
    AREA_CORRECT
  } ahc_area_t;

  // Highest device number per area
  localparam logic [11:0] MAX_FLAG = 12'h04f;
  localparam logic [11:0] MAX_CURRENT = 12'h0a0;
  localparam logic [11:0] MAX_COMMON = 12'h062;
  localparam logic [11:0] MAX_RECIPE = 12'h832;
  localparam logic [11:0] MAX_EQUIP = 12'h852;
  localparam logic [11:0] MAX_FILTER = 12'h896;
  localparam logic [11:0] MAX_CORRECT = 12'h92a;

  // Recipe-change targets
  typedef enum logic [1:0] {
    RCH_NONE,
    RCH_MEASURE,
    RCH_DISPLAY,
    RCH_OUTPUT
  } ahc_rch_t;

  // ==========================================================================
  // Error codes
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_CHECKSUM = 8'h01;
  localparam logic [7:0] ERR_COMMAND = 8'h02;
  localparam logic [7:0] ERR_RANGE = 8'h03;
  localparam logic [7:0] ERR_WORD_TO_FLAG = 8'h04;
  localparam logic [7:0] ERR_ODD_COUNT = 8'h05;
  localparam logic [7:0] ERR_ODD_ADDR = 8'h06;
  localparam logic [7:0] ERR_MEAS_UNREG = 8'h07;
  localparam logic [7:0] ERR_DISP_UNREG = 8'h08;
  localparam logic [7:0] ERR_OUT_UNREG = 8'h09;
  localparam logic [7:0] ERR_DISP_UNMEAS = 8'h0a;
  localparam logic [7:0] ERR_OUT_UNMEAS = 8'h0b;

  // Station identifier limits and reset values
  localparam logic [3:0] STATION_MIN = 4'h1;
  localparam logic [3:0] STATION_MAX = 4'ha;
  localparam logic [3:0] STATION_RESET = 4'h1;
  // Edges the strap synchroniser needs before its value is trusted
  localparam logic [1:0] STRAP_SETTLE = 2'h2;
  localparam int RECIPES = 32;

endpackage

// file: hdl/ahc_recipe_table.sv
// Purpose: remembers which recipes were written and looks up which are measuring
// Assumes: one update per cycle at most
// Notes: registered and measuring flags are separate bit arrays
`timescale 1ns/10ps
module ahc_recipe_table #(
  parameter int RECIPES = ahc_pkg::RECIPES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Registration by a recipe store write pulse
  input wire logic regStb,
  input wire logic [4:0] regNum,
  // Measurement state from the analyzer core
  input wire logic [RECIPES-1:0] measuring,
  // Lookup
  input wire logic [4:0] qNum,
  output logic qRegistered,
  output logic qMeasuring
);

  // ==========================================================================
  // Elaboration check
  if (RECIPES < 1 || RECIPES > 32)
  begin : g_bad
    $error("RECIPES out of range");
  end

  logic [RECIPES-1:0] reg_q;
  logic [RECIPES-1:0] reg_d;

  // Registered flags only ever set; cleared by reset
  always_comb
  begin
    reg_d = reg_q;
    if (regStb && (32'(regNum) < RECIPES))
    begin
      reg_d[regNum] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      reg_q <= '0;
    end
    else
    begin
      reg_q <= reg_d;
    end
  end

  // Out-of-table numbers count as neither registered nor measuring
  assign qRegistered = (32'(qNum) < RECIPES) ? reg_q[qNum] : 1'b0;
  assign qMeasuring = (32'(qNum) < RECIPES) ? measuring[qNum] : 1'b0;

endmodule

// file: hdl/analyzer_host_command_checker.sv
// Purpose: checks parsed host requests and yields accept or an error code
// Assumes: a framing front end hands over one parsed request with a strobe
// Notes: checks run in a fixed priority, first failure gives the code;
//        a strap outside the legal range falls back to identifier 1
// Summary of operation
// - Checksum mismatch rejects the request with code 01.
// - Only the nine command symbols are accepted; others give code 02.
// - Device number above the area's range gives code 03.
// - Word write or extended word write to flag area gives code 04.
// - Word operations to word areas with odd count give code 05.
// - Operations to word areas with odd start address give code 06.
// - Measurement recipe change to unregistered recipe gives code 07.
// - Display recipe change to unregistered recipe gives code 08.
// - Output recipe change to unregistered recipe gives code 09.
// - Display recipe change to registered, non-measuring recipe gives code 0A.
// - Output recipe change to registered, non-measuring recipe gives code 0B.
// - Station identifier 1 to 10; only own identifier is answered.
`timescale 1ns/10ps
module analyzer_host_command_checker #(
  parameter int RECIPES = ahc_pkg::RECIPES
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rstn,
  // Station identifier strap, sampled after reset
  input wire logic [3:0] stationSel,
  // Parsed request from the framing front end
  input wire logic reqValid,
  input wire logic [3:0] reqStation,
  input wire logic [15:0] reqSymbol,
  input wire logic [7:0] reqSumRx,
  input wire logic [7:0] reqSumCalc,
  input wire ahc_pkg::ahc_area_t reqArea,
  input wire logic [11:0] reqAddr,
  input wire logic [7:0] reqCount,
  input wire ahc_pkg::ahc_rch_t reqRecipeChange,
  input wire logic [4:0] reqRecipeNum,
  // Recipe store activity and measurement state
  input wire logic recipeWrite,
  input wire logic [4:0] recipeWriteNum,
  input wire logic [RECIPES-1:0] measuring,
  // Verdict
  output logic rspValid,
  output logic rspOk,
  output logic [7:0] rspCode,
  output logic execStb,
  output logic stationBad
);

  // ==========================================================================
  // Elaboration check
  // Recipe numbers arrive on five bits, so the table cannot exceed 32
  if (RECIPES < 1 || RECIPES > 32)
  begin : g_bad_recipes
    $error("RECIPES out of range");
  end

  // ==========================================================================
  // Station identifier capture
  logic [3:0] stationSync1_q;
  logic [3:0] stationSync2_q;
  logic [3:0] station_q;
  logic [3:0] station_d;
  logic stationTaken_q;
  logic stationTaken_d;
  logic stationBad_q;
  logic stationBad_d;

  // Legal strap values; shared by the capture and the fault flag
  function automatic logic stationInRange(input logic [3:0] s);
    stationInRange = (s >= ahc_pkg::STATION_MIN) && (s <= ahc_pkg::STATION_MAX);
  endfunction

  // Strap is a pin: two flops before anything reads it
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      stationSync1_q <= 4'h0;
      stationSync2_q <= 4'h0;
    end
    else
    begin
      stationSync1_q <= stationSel;
      stationSync2_q <= stationSync1_q;
    end
  end

  // Capture once after the synchroniser has filled; out of range keeps default
  logic [1:0] fill_q;
  logic [1:0] fill_d;
  always_comb
  begin
    fill_d = fill_q;
    station_d = station_q;
    stationTaken_d = stationTaken_q;
    stationBad_d = stationBad_q;
    if (fill_q != ahc_pkg::STRAP_SETTLE)
    begin
      fill_d = fill_q + 2'h1;
    end
    else if (!stationTaken_q)
    begin
      stationTaken_d = 1'b1;
      stationBad_d = !stationInRange(stationSync2_q);
      if (stationInRange(stationSync2_q))
      begin
        station_d = stationSync2_q;
      end
    end
  end

  // Capture flops; the fault flag is registered so it never glitches
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      fill_q <= 2'h0;
      station_q <= ahc_pkg::STATION_RESET;
      stationTaken_q <= 1'b0;
      stationBad_q <= 1'b0;
    end
    else
    begin
      fill_q <= fill_d;
      station_q <= station_d;
      stationTaken_q <= stationTaken_d;
      stationBad_q <= stationBad_d;
    end
  end

  // ==========================================================================
  // Command decode and recipe lookup
  ahc_pkg::ahc_cmd_t cmd;
  logic isWordWrite;
  logic isWordOp;
  logic isWrite;
  logic qRegistered;
  logic qMeasuring;
  logic regStb;

  // Symbol to command class
  ahc_cmd_decode u_decode (
    .symbol(reqSymbol),
    .cmd(cmd),
    .isWordWrite(isWordWrite),
    .isWordOp(isWordOp),
    .isWrite(isWrite)
  );

  // Registered and measuring lookup for the requested recipe
  ahc_recipe_table #(
    .RECIPES(RECIPES)
  ) u_recipes (
    .ref_clk(ref_clk),
    .rstn(rstn),
    .regStb(regStb),
    .regNum(recipeWriteNum),
    .measuring(measuring),
    .qNum(reqRecipeNum),
    .qRegistered(qRegistered),
    .qMeasuring(qMeasuring)
  );

  // Registration from any store write pulse; not gated by request acceptance
  assign regStb = recipeWrite;

  // ==========================================================================
  // Area helpers
  function automatic logic [11:0] areaMax(input ahc_pkg::ahc_area_t a);
    case (a)
      ahc_pkg::AREA_FLAG: areaMax = ahc_pkg::MAX_FLAG;
      ahc_pkg::AREA_CURRENT: areaMax = ahc_pkg::MAX_CURRENT;
      ahc_pkg::AREA_COMMON: areaMax = ahc_pkg::MAX_COMMON;
      ahc_pkg::AREA_RECIPE: areaMax = ahc_pkg::MAX_RECIPE;
      ahc_pkg::AREA_EQUIP: areaMax = ahc_pkg::MAX_EQUIP;
      ahc_pkg::AREA_FILTER: areaMax = ahc_pkg::MAX_FILTER;
      ahc_pkg::AREA_CORRECT: areaMax = ahc_pkg::MAX_CORRECT;
      default: areaMax = 12'h000;
    endcase
  endfunction

  function automatic logic isWordArea(input ahc_pkg::ahc_area_t a);
    isWordArea = (a != ahc_pkg::AREA_FLAG);
  endfunction

  // ==========================================================================
  // Priority check chain; first failing test names the code
  logic [7:0] code;
  logic [11:0] lastAddr;
  logic ownStation;

  // Last device touched; a zero count is treated as one device
  assign lastAddr = reqAddr + ((reqCount == 8'h00) ? 12'h000 : 12'(reqCount - 8'h01));
  assign ownStation = (reqStation == station_q);

  // First failing check wins; later codes never mask an earlier one
  always_comb
  begin
    code = ahc_pkg::ERR_NONE;
    if (reqSumRx != reqSumCalc)
    begin
      code = ahc_pkg::ERR_CHECKSUM;
    end
    else if (cmd == ahc_pkg::CMD_UNKNOWN)
    begin
      code = ahc_pkg::ERR_COMMAND;
    end
    else if (cmd != ahc_pkg::CMD_LINK_TEST && (reqAddr > areaMax(reqArea)
             || lastAddr > areaMax(reqArea) || lastAddr < reqAddr))
    begin
      code = ahc_pkg::ERR_RANGE;
    end
    else if (isWordWrite && !isWordArea(reqArea))
    begin
      code = ahc_pkg::ERR_WORD_TO_FLAG;
    end
    else if (isWordOp && isWordArea(reqArea) && reqCount[0])
    begin
      code = ahc_pkg::ERR_ODD_COUNT;
    end
    else if (cmd != ahc_pkg::CMD_LINK_TEST && isWordArea(reqArea) && reqAddr[0])
    begin
      code = ahc_pkg::ERR_ODD_ADDR;
    end
    else if (isWrite && reqRecipeChange == ahc_pkg::RCH_MEASURE && !qRegistered)
    begin
      code = ahc_pkg::ERR_MEAS_UNREG;
    end
    else if (isWrite && reqRecipeChange == ahc_pkg::RCH_DISPLAY && !qRegistered)
    begin
      code = ahc_pkg::ERR_DISP_UNREG;
    end
    else if (isWrite && reqRecipeChange == ahc_pkg::RCH_OUTPUT && !qRegistered)
    begin
      code = ahc_pkg::ERR_OUT_UNREG;
    end
    else if (isWrite && reqRecipeChange == ahc_pkg::RCH_DISPLAY && !qMeasuring)
    begin
      code = ahc_pkg::ERR_DISP_UNMEAS;
    end
    else if (isWrite && reqRecipeChange == ahc_pkg::RCH_OUTPUT && !qMeasuring)
    begin
      code = ahc_pkg::ERR_OUT_UNMEAS;
    end
  end

  // ==========================================================================
  // Verdict registers
  logic rspValid_q;
  logic rspValid_d;
  logic rspOk_q;
  logic rspOk_d;
  logic [7:0] rspCode_q;
  logic [7:0] rspCode_d;
  logic execStb_q;
  logic execStb_d;

  // Foreign stations get silence so the multidrop bus stays free
  always_comb
  begin
    rspValid_d = 1'b0;
    rspOk_d = rspOk_q;
    rspCode_d = rspCode_q;
    execStb_d = 1'b0;
    if (reqValid && ownStation)
    begin
      rspValid_d = 1'b1;
      rspOk_d = (code == ahc_pkg::ERR_NONE);
      rspCode_d = code;
      execStb_d = (code == ahc_pkg::ERR_NONE);
    end
  end

  // Verdict flops; reset leaves a silent, not-ok answer
  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      rspValid_q <= 1'b0;
      rspOk_q <= 1'b0;
      rspCode_q <= ahc_pkg::ERR_NONE;
      execStb_q <= 1'b0;
    end
    else
    begin
      rspValid_q <= rspValid_d;
      rspOk_q <= rspOk_d;
      rspCode_q <= rspCode_d;
      execStb_q <= execStb_d;
    end
  end

  assign rspValid = rspValid_q;
  assign rspOk = rspOk_q;
  assign rspCode = rspCode_q;
  assign execStb = execStb_q;
  // Strap outside 1..10 flags a set-up fault; default identifier is used
  assign stationBad = stationBad_q;

endmodule
